// ===== rtl/hpm_pkg.sv
// shared constants and types for the hot-plug message and interrupt block
package hpm_pkg;

  // hot-plug virtual-wire message codes on the local message ports
  typedef enum logic [3:0] {
    HPM_ATTN_ON    = 4'h0,
    HPM_ATTN_BLINK = 4'h1,
    HPM_ATTN_OFF   = 4'h2,
    HPM_PWR_ON     = 4'h4,
    HPM_PWR_BLINK  = 4'h5,
    HPM_PWR_OFF    = 4'h6,
    HPM_BUTTON     = 4'h8
  } hpm_msg_t;

  // indicator control field encoding
  typedef enum logic [1:0] {
    HPM_IND_RSVD  = 2'h0,
    HPM_IND_ON    = 2'h1,
    HPM_IND_BLINK = 2'h2,
    HPM_IND_OFF   = 2'h3
  } hpm_ind_t;

  // slot status flag positions
  localparam int HPM_NEV = 5;
  localparam int HPM_EV_BUTTON = 0;
  localparam int HPM_EV_PWR_FAULT = 1;
  localparam int HPM_EV_LATCH = 2;
  localparam int HPM_EV_PRESENCE = 3;
  localparam int HPM_EV_CMD_DONE = 4;
  localparam logic [4:0] HPM_STATUS_RST = 5'h00;
  localparam logic [4:0] HPM_WAKE_MASK = 5'h0f;

  // message field positions
  localparam int HPM_MSG_W = 4;
  localparam logic [1:0] HPM_GRP_ATTN = 2'h0;
  localparam logic [1:0] HPM_GRP_PWR = 2'h1;

  // timing
  localparam int HPM_CLK_HZ = 50000000;
  localparam int HPM_SAMPLE_MS = 40;
  localparam int HPM_SAMPLE_CYCLES = (HPM_CLK_HZ / 1000) * HPM_SAMPLE_MS;
  localparam int HPM_BLINK_HALF_MS = 500;
  localparam int HPM_BLINK_HALF_CYCLES = (HPM_CLK_HZ / 1000) * HPM_BLINK_HALF_MS;

endpackage

// ===== rtl/hpm_indicator.sv
// one upstream indicator pin: on, blink or off, released during reset
`timescale 1ns/1ps
module hpm_indicator (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // control
  input wire logic present_in,
  input wire logic load_in,
  input wire hpm_pkg::hpm_ind_t mode_in,
  input wire logic blink_in,
  // pin
  output logic led_out,
  output logic led_oe_out
);
  import hpm_pkg::*;

  hpm_ind_t mode_q;
  logic led_q;
  logic oe_q;
  logic led_d;

  assign led_d = (mode_q == HPM_IND_ON) | ((mode_q == HPM_IND_BLINK) & blink_in);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= HPM_IND_OFF;
      led_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (load_in) begin
        mode_q <= mode_in;
      end
      led_q <= led_d;
      oe_q <= present_in;
    end
  end

  assign led_out = led_q;
  assign led_oe_out = oe_q;
endmodule

// ===== rtl/hpm_core.sv
// hot-plug message generation, slot interrupts and wake, upstream pins
//
// Behaviour
// - revision 1.1 mode: no downstream indicator messages
// - revision 1.1 mode: drop downstream received messages
// - default mode: generate and process downstream messages
// - attention field change sends attention message
// - power field change sends power message
// - button message sets flag, always consumed
// - no interrupt without slot interrupt enable
// - unmasked set status flag raises interrupt
// - msi if enabled, else intx unless disabled
// - d3hot, global enable clear: wake instead
// - d3hot, global enable set: wake and interrupt
// - d3hot masked event: neither wake nor interrupt
// - command completed never causes wake
// - revision 1.1 mode: upstream messages discarded, none sent
// - default mode: upstream messages generated and processed
// - power messages drive upstream power indicator
// - attention messages drive upstream attention indicator
// - upstream button press sends button message
// - sample button once per 40 ms
// - pins undriven during reset, even unclocked
`timescale 1ns/1ps
module hpm_core #(
  parameter int NP = 2,
  parameter int SAMPLE_CYCLES = hpm_pkg::HPM_SAMPLE_CYCLES,
  parameter int BLINK_HALF_CYCLES = hpm_pkg::HPM_BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // switch mode
  input wire logic hot_plug_revision_select_in,
  // downstream slot control, per port
  input wire logic [NP-1:0] ds_ctrl_enable_in,
  input wire logic [2*NP-1:0] attention_indicator_control_field_in,
  input wire logic [2*NP-1:0] power_indicator_control_field_in,
  input wire logic [hpm_pkg::HPM_NEV*NP-1:0] slot_event_enable_in,
  input wire logic [NP-1:0] hot_plug_irq_enable_in,
  input wire logic [NP-1:0] msi_enable_in,
  input wire logic [NP-1:0] legacy_irq_disable_in,
  input wire logic [NP-1:0] d3hot_in,
  // downstream slot status, per port
  input wire logic [hpm_pkg::HPM_NEV*NP-1:0] slot_event_set_in,
  input wire logic [hpm_pkg::HPM_NEV*NP-1:0] slot_status_clear_in,
  output logic [hpm_pkg::HPM_NEV*NP-1:0] slot_status_out,
  // downstream messages, per port
  input wire logic [NP-1:0] ds_rx_valid_in,
  input wire logic [hpm_pkg::HPM_MSG_W*NP-1:0] ds_rx_code_in,
  input wire logic [NP-1:0] ds_tx_ready_in,
  output logic [NP-1:0] ds_tx_valid_out,
  output logic [hpm_pkg::HPM_MSG_W*NP-1:0] ds_tx_code_out,
  // downstream interrupt and wake requests, per port
  output logic [NP-1:0] msi_req_out,
  output logic [NP-1:0] intx_out,
  output logic [NP-1:0] pme_req_out,
  // upstream capabilities and pin functions
  input wire logic attention_button_present_in,
  input wire logic attention_indicator_present_in,
  input wire logic power_indicator_present_in,
  input wire logic button_pin_alt_in,
  input wire logic attention_pin_alt_in,
  input wire logic power_pin_alt_in,
  // upstream messages
  input wire logic us_rx_valid_in,
  input wire logic [hpm_pkg::HPM_MSG_W-1:0] us_rx_code_in,
  input wire logic us_tx_ready_in,
  output logic us_tx_valid_out,
  output logic [hpm_pkg::HPM_MSG_W-1:0] us_tx_code_out,
  // upstream pins
  input wire logic upstream_button_n_in,
  output logic upstream_attention_led_out,
  output logic upstream_attention_led_oe_out,
  output logic upstream_power_led_out,
  output logic upstream_power_led_oe_out
);
  import hpm_pkg::*;

  logic rev11;
  assign rev11 = hot_plug_revision_select_in;

  ////////////////////////////////////////////////////////////////////////
  // downstream ports

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic [1:0] attn_f;
      logic [1:0] pwr_f;
      logic [1:0] attn_prev_q;
      logic [1:0] pwr_prev_q;
      logic [1:0] pend_q;
      logic [1:0] pend_d;
      logic [1:0] pend_set;
      logic [1:0] take;
      logic tx_valid_q;
      logic [HPM_MSG_W-1:0] tx_code_q;
      logic tx_free;
      logic tx_load;
      logic [HPM_MSG_W-1:0] attn_code;
      logic [HPM_MSG_W-1:0] pwr_code;
      logic [HPM_NEV-1:0] stat_q;
      logic [HPM_NEV-1:0] stat_d;
      logic [HPM_NEV-1:0] ev_en;
      logic [HPM_NEV-1:0] stat_set;
      logic rx_button;
      logic active;
      logic irq;
      logic wake;
      logic irq_prev_q;
      logic wake_prev_q;
      logic msi_q;
      logic intx_q;
      logic pme_q;

      assign attn_f = attention_indicator_control_field_in[2*p +: 2];
      assign pwr_f = power_indicator_control_field_in[2*p +: 2];
      assign ev_en = slot_event_enable_in[HPM_NEV*p +: HPM_NEV];
      assign active = ds_ctrl_enable_in[p] & ~rev11;

      assign pend_set[0] = active & (attn_f != attn_prev_q) & (attn_f != HPM_IND_RSVD);
      assign pend_set[1] = active & (pwr_f != pwr_prev_q) & (pwr_f != HPM_IND_RSVD);
      assign attn_code = {HPM_GRP_ATTN, attn_f - 2'h1};
      assign pwr_code = {HPM_GRP_PWR, pwr_f - 2'h1};

      // attention goes first when both fields change together
      assign tx_free = ~tx_valid_q | ds_tx_ready_in[p];
      assign tx_load = tx_free & (|pend_q) & ~rev11;
      assign take[0] = tx_load & pend_q[0];
      assign take[1] = tx_load & ~pend_q[0] & pend_q[1];
      // an offer already on the link stays until taken, even after a mode change
      // revision 1.1 flushes pending messages
      assign pend_d = rev11 ? 2'h0 : (pend_set | (pend_q & ~take));

      // button message sets flag, never forwarded
      assign rx_button = ds_rx_valid_in[p] & active & (ds_rx_code_in[HPM_MSG_W*p +: HPM_MSG_W] == HPM_BUTTON);
      // set wins over a same-cycle clear
      assign stat_set = slot_event_set_in[HPM_NEV*p +: HPM_NEV] | {{(HPM_NEV-1){1'b0}}, rx_button};
      assign stat_d = stat_set | (stat_q & ~slot_status_clear_in[HPM_NEV*p +: HPM_NEV]);

      // unmasked flag, gated by slot enable
      assign irq = hot_plug_irq_enable_in[p] & (|(stat_q & ev_en));
      assign wake = d3hot_in[p] & (|(stat_q & ev_en & HPM_WAKE_MASK));

      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          attn_prev_q <= HPM_IND_OFF;
          pwr_prev_q <= HPM_IND_OFF;
          pend_q <= 2'h0;
          tx_valid_q <= 1'b0;
          tx_code_q <= HPM_ATTN_OFF;
          stat_q <= HPM_STATUS_RST;
          irq_prev_q <= 1'b0;
          wake_prev_q <= 1'b0;
          msi_q <= 1'b0;
          intx_q <= 1'b0;
          pme_q <= 1'b0;
        end else begin
          attn_prev_q <= attn_f;
          pwr_prev_q <= pwr_f;
          pend_q <= pend_d;
          if (tx_load) begin
            tx_valid_q <= 1'b1;
            tx_code_q <= take[0] ? attn_code : pwr_code;
          end else if (tx_free) begin
            tx_valid_q <= 1'b0;
          end
          stat_q <= stat_d;
          irq_prev_q <= irq;
          wake_prev_q <= wake;
          msi_q <= irq & ~irq_prev_q & msi_enable_in[p];
          intx_q <= irq & ~msi_enable_in[p] & ~legacy_irq_disable_in[p];
          // wake on new unmasked event in d3hot
          pme_q <= wake & ~wake_prev_q;
        end
      end

      assign ds_tx_valid_out[p] = tx_valid_q;
      assign ds_tx_code_out[HPM_MSG_W*p +: HPM_MSG_W] = tx_code_q;
      assign slot_status_out[HPM_NEV*p +: HPM_NEV] = stat_q;
      assign msi_req_out[p] = msi_q;
      assign intx_out[p] = intx_q;
      assign pme_req_out[p] = pme_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // upstream received indicator messages

  logic us_rx_ok;
  logic us_attn_en;
  logic us_pwr_en;
  logic us_attn_load;
  logic us_pwr_load;
  logic [1:0] us_rx_grp;
  hpm_ind_t us_rx_mode;

  // nothing processed in revision 1.1 mode
  assign us_rx_ok = us_rx_valid_in & ~rev11;
  assign us_rx_grp = us_rx_code_in[3:2];
  assign us_rx_mode = hpm_ind_t'(us_rx_code_in[1:0] + 2'h1);
  assign us_attn_en = attention_indicator_present_in & attention_pin_alt_in;
  assign us_pwr_en = power_indicator_present_in & power_pin_alt_in;
  // attention messages consumed into the pin
  assign us_attn_load = us_rx_ok & us_attn_en & (us_rx_grp == HPM_GRP_ATTN) & (us_rx_code_in[1:0] != 2'h3);
  // power messages consumed into the pin
  assign us_pwr_load = us_rx_ok & us_pwr_en & (us_rx_grp == HPM_GRP_PWR) & (us_rx_code_in[1:0] != 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // blink timebase and button sampling

  logic [31:0] blink_cnt_q;
  logic blink_q;
  logic [31:0] samp_cnt_q;
  logic samp_tick;
  logic button_q;
  logic button_d;
  logic press;
  logic us_pend_q;
  logic us_tx_valid_q;
  logic us_tx_free;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blink_cnt_q <= 32'h0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_q <= 32'h0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  assign samp_tick = (samp_cnt_q == 32'(SAMPLE_CYCLES - 1));
  // bounces inside a window are never seen, so no extra filter
  assign button_d = samp_tick ? ~upstream_button_n_in : button_q;
  // press only with capability and pin function
  assign press = samp_tick & button_d & ~button_q & attention_button_present_in & button_pin_alt_in;
  assign us_tx_free = ~us_tx_valid_q | us_tx_ready_in;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      samp_cnt_q <= 32'h0;
      button_q <= 1'b0;
      us_pend_q <= 1'b0;
      us_tx_valid_q <= 1'b0;
    end else begin
      samp_cnt_q <= samp_tick ? 32'h0 : samp_cnt_q + 32'h1;
      button_q <= button_d;
      // send in default mode, never in 1.1
      if (rev11) begin
        us_pend_q <= 1'b0;
      end else if (press) begin
        us_pend_q <= 1'b1;
      end else if (us_tx_free) begin
        us_pend_q <= 1'b0;
      end
      if (us_tx_free) begin
        us_tx_valid_q <= us_pend_q & ~rev11;
      end
    end
  end

  assign us_tx_valid_out = us_tx_valid_q;
  assign us_tx_code_out = HPM_BUTTON;

  ////////////////////////////////////////////////////////////////////////
  // upstream indicator pins

  hpm_indicator u_attn (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .present_in(us_attn_en),
    .load_in(us_attn_load),
    .mode_in(us_rx_mode),
    .blink_in(blink_q),
    .led_out(upstream_attention_led_out),
    .led_oe_out(upstream_attention_led_oe_out)
  );

  hpm_indicator u_pwr (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .present_in(us_pwr_en),
    .load_in(us_pwr_load),
    .mode_in(us_rx_mode),
    .blink_in(blink_q),
    .led_out(upstream_power_led_out),
    .led_oe_out(upstream_power_led_oe_out)
  );

endmodule

// ===== dv/hpm_core_assertions.sv
// concurrent checks on the hot-plug message and interrupt core ports
`timescale 1ns/1ps
module hpm_core_assertions #(
  parameter int NP = 2
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // mode and slot control
  input wire logic hot_plug_revision_select_in,
  input wire logic [NP-1:0] ds_ctrl_enable_in,
  input wire logic [5*NP-1:0] slot_event_enable_in,
  input wire logic [NP-1:0] hot_plug_irq_enable_in,
  input wire logic [NP-1:0] msi_enable_in,
  input wire logic [NP-1:0] legacy_irq_disable_in,
  input wire logic [NP-1:0] d3hot_in,
  input wire logic [5*NP-1:0] slot_event_set_in,
  input wire logic [5*NP-1:0] slot_status_out,
  // messages
  input wire logic [NP-1:0] ds_rx_valid_in,
  input wire logic [4*NP-1:0] ds_rx_code_in,
  input wire logic [NP-1:0] ds_tx_ready_in,
  input wire logic [NP-1:0] ds_tx_valid_out,
  input wire logic [4*NP-1:0] ds_tx_code_out,
  input wire logic us_tx_ready_in,
  input wire logic us_tx_valid_out,
  // requests and pins
  input wire logic [NP-1:0] msi_req_out,
  input wire logic [NP-1:0] intx_out,
  input wire logic [NP-1:0] pme_req_out,
  input wire logic upstream_attention_led_oe_out,
  input wire logic upstream_power_led_oe_out
);
  wire logic irq0 = hot_plug_irq_enable_in[0] & |(slot_status_out[4:0] & slot_event_enable_in[4:0]);
  // command completed left out of the wake term
  wire logic wake0 = d3hot_in[0] & |(slot_status_out[3:0] & slot_event_enable_in[3:0]);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////
  a_rev_no_ds: assert property (hot_plug_revision_select_in [*3] |-> ds_tx_valid_out == '0)
    else $error("downstream message in revision mode");
  a_rev_no_us: assert property (hot_plug_revision_select_in [*3] |-> !us_tx_valid_out)
    else $error("upstream message in revision mode");
  a_no_irq_off: assert property (!$past(hot_plug_irq_enable_in[0]) |-> !msi_req_out[0] && !intx_out[0])
    else $error("interrupt without slot enable");
  a_intx_level: assert property (intx_out[0] ==
      $past(irq0 && !msi_enable_in[0] && !legacy_irq_disable_in[0]))
    else $error("legacy interrupt level wrong");
  a_msi_on_rise: assert property ($rose(irq0) && msi_enable_in[0] |=> msi_req_out[0])
    else $error("msi missing after event");
  a_msi_one_cycle: assert property (msi_req_out[0] |=> !msi_req_out[0])
    else $error("msi longer than one cycle");
  a_wake_rise: assert property ($rose(wake0) |=> pme_req_out[0])
    else $error("wake message missing");
  a_wake_cause: assert property (pme_req_out[0] |-> $past(wake0))
    else $error("wake message without cause");
  a_button_flag: assert property (ds_rx_valid_in[0] && ds_rx_code_in[3:0] == 4'h8 && ds_ctrl_enable_in[0] &&
      !hot_plug_revision_select_in |=> slot_status_out[0])
    else $error("button flag not set");
  a_rev_rx_drop: assert property (hot_plug_revision_select_in && !slot_status_out[0] &&
      !slot_event_set_in[0] |=> !slot_status_out[0])
    else $error("message taken in revision mode");
  a_ds_hold: assert property (ds_tx_valid_out[0] && !ds_tx_ready_in[0] && !hot_plug_revision_select_in
      |=> ds_tx_valid_out[0] && $stable(ds_tx_code_out[3:0]))
    else $error("downstream message dropped while stalled");
  a_us_hold: assert property (us_tx_valid_out && !us_tx_ready_in && !hot_plug_revision_select_in
      |=> us_tx_valid_out)
    else $error("upstream message dropped while stalled");
  a_reset_float: assert property (disable iff (1'b0) !reset_n_in |-> !upstream_attention_led_oe_out &&
      !upstream_power_led_oe_out && !us_tx_valid_out && ds_tx_valid_out == '0)
    else $error("pin driven during reset");
  c_msi: cover property (msi_req_out[0]);
  c_pme: cover property (pme_req_out[0]);
  c_us_msg: cover property (us_tx_valid_out && us_tx_ready_in);
endmodule
bind hpm_core hpm_core_assertions #(.NP(NP)) u_chk (.*);

// ===== dv/hpm_link_model.sv
// link partner: takes hot-plug messages, may stall, counts them
`timescale 1ns/1ps
module hpm_link_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // stall request
  input wire logic stall_in,
  // messages
  input wire logic ds_valid_in,
  input wire logic [3:0] ds_code_in,
  input wire logic us_valid_in,
  output logic ds_ready_out,
  output logic us_ready_out,
  // record
  output logic [3:0] ds_last_out,
  output int ds_cnt_out,
  output int us_cnt_out
);
  assign ds_ready_out = ~stall_in;
  assign us_ready_out = ~stall_in;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ds_cnt_out <= 0;
      us_cnt_out <= 0;
      ds_last_out <= 4'h0;
    end else begin
      if (ds_valid_in && ds_ready_out) begin
        ds_cnt_out <= ds_cnt_out + 1;
        ds_last_out <= ds_code_in;
      end
      if (us_valid_in && us_ready_out) begin
        us_cnt_out <= us_cnt_out + 1;
      end
    end
  end
endmodule

// ===== dv/hot_plug_message_interrupt_test.sv
// self-checking bench for the hot-plug message and interrupt core
`timescale 1ns/1ps
module hot_plug_message_interrupt_test;
  localparam int NP = 2;
  localparam int SC = 8;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b1;
  logic hot_plug_revision_select_in = 1'b0;
  logic [1:0] ds_ctrl_enable_in = 2'h3;
  logic [1:0] hot_plug_irq_enable_in = 2'h0;
  logic [1:0] msi_enable_in = 2'h0;
  logic [1:0] legacy_irq_disable_in = 2'h0;
  logic [1:0] d3hot_in = 2'h0;
  logic [1:0] ds_rx_valid_in = 2'h0;
  logic [3:0] attention_indicator_control_field_in = 4'hf;
  logic [3:0] power_indicator_control_field_in = 4'hf;
  logic [9:0] slot_event_enable_in = 10'h000;
  logic [9:0] slot_event_set_in = 10'h000;
  logic [9:0] slot_status_clear_in = 10'h000;
  logic [7:0] ds_rx_code_in = 8'h00;
  logic [3:0] us_rx_code_in = 4'h0;
  logic us_rx_valid_in = 1'b0;
  logic attention_button_present_in = 1'b1;
  logic attention_indicator_present_in = 1'b1;
  logic power_indicator_present_in = 1'b1;
  logic button_pin_alt_in = 1'b1;
  logic attention_pin_alt_in = 1'b1;
  logic power_pin_alt_in = 1'b1;
  logic upstream_button_n_in = 1'b1;
  logic stall = 1'b0;
  wire logic ds_rdy;
  wire logic [1:0] ds_tx_ready_in = {1'b1, ds_rdy};
  wire logic us_tx_ready_in;
  wire logic [9:0] slot_status_out;
  wire logic [1:0] ds_tx_valid_out, msi_req_out, intx_out, pme_req_out;
  wire logic [7:0] ds_tx_code_out;
  wire logic [3:0] us_tx_code_out, ds_last;
  wire logic us_tx_valid_out, upstream_attention_led_out, upstream_attention_led_oe_out;
  wire logic upstream_power_led_out, upstream_power_led_oe_out;
  int ds_cnt, us_cnt, n_fail = 0, n_checks = 0, cyc = 0;
  hpm_core #(.NP(NP), .SAMPLE_CYCLES(SC), .BLINK_HALF_CYCLES(4)) u_dut (.*);
  hpm_link_model u_link (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .stall_in(stall),
    .ds_valid_in(ds_tx_valid_out[0]), .ds_code_in(ds_tx_code_out[3:0]), .us_valid_in(us_tx_valid_out),
    .ds_ready_out(ds_rdy), .us_ready_out(us_tx_ready_in), .ds_last_out(ds_last), .ds_cnt_out(ds_cnt),
    .us_cnt_out(us_cnt));
  always #10 mclk_in = ~mclk_in;
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic clear_all();
    slot_status_clear_in = 10'h3ff;
    tick();
    slot_status_clear_in = 10'h000;
    tick(2);
  endtask
  task automatic us_msg(input logic [3:0] code);
    us_rx_code_in = code;
    us_rx_valid_in = 1'b1;
    tick();
    us_rx_valid_in = 1'b0;
    tick(3);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    // async reset lands before any clock edge, registers start unknown
    #1;
    reset_n_in = 1'b0;
    #1;
    check("pins unclocked", {upstream_attention_led_oe_out, upstream_power_led_oe_out, us_tx_valid_out},
      8'h00);
    tick();
    check("pins in reset", {upstream_attention_led_oe_out, upstream_power_led_oe_out, us_tx_valid_out},
      8'h00);
    tick(4);
    reset_n_in = 1'b1;
    tick(2);
    check("pins after", {upstream_attention_led_oe_out, upstream_power_led_oe_out}, 8'h03);
  endtask
  task automatic t_ds_msgs();
    int was;
    for (int g = 0; g < 2; g++) begin
      for (int f = 1; f < 4; f++) begin
        was = ds_cnt;
        stall = 1'b1;
        if (g == 0) attention_indicator_control_field_in[1:0] = 2'(f);
        else power_indicator_control_field_in[1:0] = 2'(f);
        tick(6);
        check("ds held", {ds_tx_valid_out[0], ds_tx_code_out[3:0]}, 8'(16 + 4 * g + f - 1));
        stall = 1'b0;
        for (int i = 0; i < 20 && ds_cnt == was; i++) tick();
        check("ds code", {4'h0, ds_last}, 8'(4 * g + f - 1));
      end
    end
  endtask
  task automatic t_rx_button();
    int was;
    was = us_cnt;
    ds_rx_code_in[3:0] = 4'h8;
    ds_rx_valid_in[0] = 1'b1;
    tick();
    ds_rx_valid_in[0] = 1'b0;
    tick();
    check("button flag", slot_status_out[4:0], 8'h01);
    check("not forwarded", 8'(us_cnt - was), 8'h00);
    clear_all();
  endtask
  task automatic ev_case(input int ev, input logic en, hot_plug_irq_enable, msi, dis, d3, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    slot_event_enable_in[4:0] = en ? 5'h1f : 5'h00;
    hot_plug_irq_enable_in[0] = hot_plug_irq_enable;
    msi_enable_in[0] = msi;
    legacy_irq_disable_in[0] = dis;
    d3hot_in[0] = d3;
    tick();
    slot_event_set_in[ev] = 1'b1;
    tick();
    slot_event_set_in[ev] = 1'b0;
    repeat (4) begin
      seen |= {5'h00, msi_req_out[0], intx_out[0], pme_req_out[0]};
      tick();
    end
    check("event outputs", seen, exp);
    clear_all();
  endtask
  task automatic t_events();
    for (int e = 0; e < 5; e++) ev_case(e, 1, 1, 1, 0, 0, 8'h04);
    ev_case(1, 1, 1, 0, 0, 0, 8'h02);
    ev_case(1, 1, 1, 0, 1, 0, 8'h00);
    ev_case(1, 1, 0, 1, 0, 0, 8'h00);
    ev_case(1, 0, 1, 1, 0, 0, 8'h00);
    ev_case(2, 1, 0, 1, 0, 1, 8'h01);
    ev_case(2, 1, 1, 1, 0, 1, 8'h05);
    ev_case(2, 0, 1, 1, 0, 1, 8'h00);
    ev_case(4, 1, 0, 1, 0, 1, 8'h00);
    d3hot_in[0] = 1'b0;
  endtask
  task automatic t_us_leds();
    logic [7:0] seen;
    us_msg(4'h0);
    us_msg(4'h6);
    check("leds", {upstream_attention_led_out, upstream_power_led_out}, 8'h02);
    us_msg(4'h4);
    us_msg(4'h2);
    check("leds", {upstream_attention_led_out, upstream_power_led_out}, 8'h01);
    // pin not in its alternate function: message ignored, pin released
    attention_pin_alt_in = 1'b0;
    us_msg(4'h0);
    check("alt off", {upstream_attention_led_oe_out, upstream_attention_led_out}, 8'h00);
    attention_pin_alt_in = 1'b1;
    us_msg(4'h5);
    seen = 8'h00;
    repeat (12) begin
      seen |= upstream_power_led_out ? 8'h02 : 8'h01;
      tick();
    end
    check("blink levels", seen, 8'h03);
  endtask
  task automatic t_us_button();
    int was;
    was = us_cnt;
    upstream_button_n_in = 1'b0;
    for (int i = 0; i < 3 * SC && !us_tx_valid_out; i++) tick();
    check("us code", {3'h0, us_tx_valid_out, us_tx_code_out}, 8'h18);
    tick(2 * SC);
    check("one press", 8'(us_cnt - was), 8'h01);
    upstream_button_n_in = 1'b1;
    tick(3 * SC);
  endtask
  task automatic t_rev();
    int was_ds;
    int was_us;
    was_ds = ds_cnt;
    was_us = us_cnt;
    hot_plug_revision_select_in = 1'b1;
    tick(3);
    attention_indicator_control_field_in[1:0] = 2'h1;
    tick(8);
    attention_indicator_control_field_in[1:0] = 2'h3;
    ds_rx_valid_in[0] = 1'b1;
    tick();
    ds_rx_valid_in[0] = 1'b0;
    us_msg(4'h0);
    upstream_button_n_in = 1'b0;
    tick(3 * SC);
    upstream_button_n_in = 1'b1;
    tick(2 * SC);
    check("no ds msg", 8'(ds_cnt - was_ds), 8'h00);
    check("rx dropped", {slot_status_out[0], upstream_attention_led_out}, 8'h00);
    check("no us msg", 8'(us_cnt - was_us), 8'h00);
    hot_plug_revision_select_in = 1'b0;
    tick(2);
  endtask
  initial begin
    t_reset();
    t_ds_msgs();
    t_rx_button();
    t_events();
    t_us_leds();
    t_us_button();
    t_rev();
    report_and_stop();
  end
endmodule
